// >>> sim/cst_sw_model.sv
// switch bank model driving the terminal pins
`timescale 1ns/10ps
module cst_sw_model (
   input  wire logic       clk_sys,  // system clock
   input  wire logic [4:0] sw_req,   // requested contact states
   input  wire logic       slow,     // 1 = contacts settle late
   output logic      [4:0] term_pin  // levels seen at the terminals
);
   logic [4:0] dly_q [3];            // settle pipeline
   // contacts reach the pins at once or three cycles late
   always_ff @(posedge clk_sys) begin
      dly_q[0] <= sw_req;
      dly_q[1] <= dly_q[0];
      dly_q[2] <= dly_q[1];
   end
   assign term_pin = slow ? dly_q[2] : sw_req;
endmodule // cst_sw_model

// >>> sim/tb_top.sv
// testbench for the coast stop and external trip block
`timescale 1ns/10ps
module tb_top;
   import cst_pkg::*;
   logic        clk_sys = 1'b0;      // system clock
   logic        rst = 1'b1;          // sync reset
   logic [4:0]  sw = 5'h00;          // 0 coast 1 fault 2 guard 3 reset
   logic        slow = 1'b0;         // late contacts
   logic [4:0]  term_pin;            // pins from switch model
   logic [4:0]  pol = 5'h00;         // polarity per terminal
   logic        run_cmd = 1'b0;      // run command
   logic        keypad_reset = 1'b0; // keypad clear
   logic        sel = 1'b0;          // restart speed select
   logic [15:0] dly = 16'h0000;      // restart delay
   logic        output_enable, speed_match, alarm_out;
   logic [7:0]  error_code;          // shown error
   logic [3:0]  trip_count;          // trip history
   int          n_mismatch = 0;      // mismatches
   int          n_compared = 0;      // comparisons
   always #12.5 clk_sys = ~clk_sys;
   cst_sw_model u_cst_sw_model (.clk_sys(clk_sys), .sw_req(sw),
      .slow(slow), .term_pin(term_pin));
   cst_ctrl u_cst_ctrl (.clk_sys(clk_sys), .rst(rst), .term_pin(term_pin),
      .input_function_assign({8'h00, CST_FN_RESET, CST_FN_GUARD,
                              CST_FN_EXTFLT, CST_FN_COAST}),
      .input_polarity_setting(pol), .run_cmd(run_cmd),
      .keypad_reset(keypad_reset), .restart_speed_select(sel),
      .restart_delay(dly), .output_enable(output_enable),
      .speed_match(speed_match), .alarm_out(alarm_out),
      .error_code(error_code), .trip_count(trip_count));
   // verdict and end of run
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // advance n cycles, land just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded wait on alarm (al=1) or output enable
   task automatic wait_sig(input bit al, input logic v, input int lim);
      int k;
      k = 0;
      while (((al ? alarm_out : output_enable) !== v) && k < lim) begin
         tick(1);
         k++;
      end
      n_compared++;
      if (k >= lim) begin
         n_mismatch++;
         $display("[FAIL] wait al=%0d expected %b seen %b", al, v,
                  (al ? alarm_out : output_enable));
         close_out();
      end
   endtask
   // keypad clear pulse
   task automatic kp_clear();
      keypad_reset = 1'b1;
      tick(1);
      keypad_reset = 1'b0;
   endtask
   // fault latch, hold after release, clear and resume
   task automatic t_trip();
      run_cmd = 1'b1;
      wait_sig(0, 1'b1, 10);
      sw[1] = 1'b1;
      tick(4);
      chk("alarm", 8'h01, {7'h00, alarm_out});
      chk("error", CST_ERR_EXTFLT, error_code);
      chk("oe trip", 8'h00, {7'h00, output_enable});
      chk("count", 8'h01, {4'h0, trip_count});
      sw[1] = 1'b0;
      tick(20);
      chk("alarm held", 8'h01, {7'h00, alarm_out});
      chk("count held", 8'h01, {4'h0, trip_count});
      kp_clear();
      wait_sig(1, 1'b0, 5);
      chk("error clr", CST_ERR_NONE, error_code);
      wait_sig(0, 1'b1, 10);
      $display("test trip done");
   endtask
   // coast stop, restart speed and delay
   task automatic t_coast();
      sel = CST_RESTART_MATCH;
      sw[0] = 1'b1;
      tick(5);
      chk("oe coast", 8'h00, {7'h00, output_enable});
      tick(50);
      chk("oe hold", 8'h00, {7'h00, output_enable});
      sw[0] = 1'b0;
      wait_sig(0, 1'b1, 10);
      chk("match", 8'h01, {7'h00, speed_match});
      sel = CST_RESTART_ZERO;
      dly = 16'h0002;
      sw[0] = 1'b1;
      tick(5);
      sw[0] = 1'b0;
      tick(3900);
      chk("oe delay", 8'h00, {7'h00, output_enable});
      wait_sig(0, 1'b1, 9000);
      chk("zero", 8'h00, {7'h00, speed_match});
      sw[0] = 1'b1;
      tick(5);
      run_cmd = 1'b0;
      sw[0] = 1'b0;
      tick(20);
      chk("oe no run", 8'h00, {7'h00, output_enable});
      dly = CST_DLY_ZERO;
      $display("test coast done");
   endtask
   // active low coast terminal with late contacts
   task automatic t_polarity();
      run_cmd = 1'b1;
      wait_sig(0, 1'b1, 10);
      slow = 1'b1;
      pol[0] = 1'b1;
      wait_sig(0, 1'b0, 8);
      sw[0] = 1'b1;
      wait_sig(0, 1'b1, 15);
      slow = 1'b0;
      tick(5);
      sw[0] = 1'b0;
      pol[0] = 1'b0;
      tick(10);
      $display("test polarity done");
   endtask
   // autostart guard at power-up and after a clear
   task automatic t_guard();
      sw[2] = 1'b1;
      rst = 1'b1;
      tick(2);
      chk("count rst", 8'h00, {4'h0, trip_count});
      tick(2);
      rst = 1'b0;
      tick(4);
      chk("guard alarm", 8'h01, {7'h00, alarm_out});
      chk("guard err", CST_ERR_GUARD, error_code);
      chk("guard oe", 8'h00, {7'h00, output_enable});
      kp_clear();
      tick(20);
      chk("no auto", 8'h00, {7'h00, output_enable});
      run_cmd = 1'b0;
      tick(3);
      run_cmd = 1'b1;
      wait_sig(0, 1'b1, 10);
      sw[1] = 1'b1;
      tick(4);
      sw[1] = 1'b0;
      chk("fault oe", 8'h00, {7'h00, output_enable});
      kp_clear();
      tick(20);
      chk("no auto 2", 8'h00, {7'h00, output_enable});
      sw[1] = 1'b1;
      tick(4);
      sw[1] = 1'b0;
      sw[3] = 1'b1;
      tick(4);
      sw[3] = 1'b0;
      wait_sig(0, 1'b1, 15);
      $display("test guard done");
   endtask
   // main sequence
   initial begin
      tick(2);
      rst = 1'b0;
      t_trip();
      t_coast();
      t_polarity();
      t_guard();
      close_out();
   end
endmodule // tb_top

// >>> verilog/cst_ctrl.sv
// coast stop and external trip control
`timescale 1ns/10ps
// What this block does
// (R1) code 11 maps terminal to coast stop
// (R2) coast active holds output disabled
// (R3) release restarts only if run held
// (R4) restart from zero or matched speed
// (R5) restart delay, zero means no wait
// (R6) per terminal polarity setting
// (R7) code 12 fault rising edge latches trip
// (R8) trip stops output, alarm at once
// (R9) fault release never clears trip
// (R10) falling edge no event, history kept
// (R11) only reset clears trip, alarm off
// (R12) run still held after reset resumes
// (R13) guard needs new run edge after keypad clear
// (R14) guard: run at power-up trips
// (R15) polarity, sync, then edge detect
module cst_ctrl
   import cst_pkg::*;
(
   input  wire logic        clk_sys,        // system clock, 40 MHz
   input  wire logic        rst,            // sync reset, power-up
   input  wire logic [4:0]  term_pin,       // raw terminal levels
   input  wire logic [39:0] input_function_assign, // 8-bit code per pin
   input  wire logic [4:0]  input_polarity_setting, // 1 = active low
   input  wire logic        run_cmd,        // run command level
   input  wire logic        keypad_reset,   // keypad reset pulse
   input  wire logic        restart_speed_select, // 1 = match rotation
   input  wire logic [15:0] restart_delay,  // wait in 100 us units
   output logic             output_enable,  // power stage on
   output logic             speed_match,    // resume matching rotation
   output logic             alarm_out,      // alarm relay
   output logic [7:0]       error_code,     // displayed error
   output logic [3:0]       trip_count      // recorded external fault trips
);
   logic [4:0]            lvl;            // clean active levels
   logic [4:0]            rise;           // off-to-on pulses
   logic [4:0]            fall;           // on-to-off pulses
   logic                  coast_stop_input;     // mapped coast level
   logic                  external_fault_input; // mapped fault edge
   logic                  powerup_autostart_guard; // mapped guard level
   logic                  reset_input_terminal;   // reset terminal edge
   logic                  run_q;          // run command history
   logic                  run_rise;       // new run edge
   logic                  first_q;        // first cycle after reset
   logic                  arm_q;          // autostart allowed
   logic                  clear_req;      // trip clear request
   cst_state_t            st_q;           // control state
   cst_state_t            st_d;           // next control state
   logic [CST_DIV_W-1:0]  div_q;          // unit tick divider
   logic                  tick;           // one-cycle unit pulse
   logic [CST_DLY_W-1:0]  wait_q;         // restart wait counter

   // one conditioner per terminal
   genvar gi;
   generate
      for (gi = 0; gi < CST_NUM_TERM; gi++) begin : g_term
         cst_term_in u_term (
            .clk_sys (clk_sys),
            .rst     (rst),
            .pin     (term_pin[gi]),
            .invert  (input_polarity_setting[gi]),  // R6
            .level   (lvl[gi]),
            .rise    (rise[gi]),
            .fall    (fall[gi])
         );
      end
   endgenerate

   // function routing by assigned code
   always_comb begin
      coast_stop_input        = 1'b0;
      external_fault_input    = 1'b0;
      powerup_autostart_guard = 1'b0;
      reset_input_terminal    = 1'b0;
      for (int i = 0; i < CST_NUM_TERM; i++) begin
         // coast stop is a level
         if (input_function_assign[8*i +: 8] == CST_FN_COAST)
            coast_stop_input = coast_stop_input | lvl[i];  // R1
         // only the off-to-on edge trips; fall is ignored
         if (input_function_assign[8*i +: 8] == CST_FN_EXTFLT)
            external_fault_input = external_fault_input | rise[i]; // R7 R10
         // guard is enabled by holding its terminal on
         if (input_function_assign[8*i +: 8] == CST_FN_GUARD)
            powerup_autostart_guard = powerup_autostart_guard | lvl[i];
         // reset terminal acts on release
         if (input_function_assign[8*i +: 8] == CST_FN_RESET)
            reset_input_terminal = reset_input_terminal | fall[i];
      end
   end

   assign run_rise  = run_cmd & ~run_q;
   assign clear_req = keypad_reset | reset_input_terminal;  // R11

   // run history and power-up marker
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_q   <= 1'b0;
         first_q <= 1'b1;
      end else begin
         run_q   <= run_cmd;
         first_q <= 1'b0;
      end
   end

   // unit tick divider
   always_ff @(posedge clk_sys) begin
      if (rst || div_q == CST_DIV_LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (div_q == CST_DIV_LAST);

   // next state
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         CST_ST_STOP: begin
            if (external_fault_input) begin
               st_d = CST_ST_TRIP;                         // R7
            end else if (run_cmd && arm_q && !coast_stop_input) begin
               st_d = CST_ST_RUN;                          // R12
            end else if (run_cmd && arm_q) begin
               st_d = CST_ST_COAST;
            end
         end
         CST_ST_RUN: begin
            if (external_fault_input) begin
               st_d = CST_ST_TRIP;                         // R8
            end else if (coast_stop_input) begin
               st_d = CST_ST_COAST;                        // R2
            end else if (!run_cmd) begin
               st_d = CST_ST_STOP;
            end
         end
         CST_ST_COAST: begin
            if (external_fault_input) begin
               st_d = CST_ST_TRIP;                         // R8
            end else if (!run_cmd) begin
               st_d = CST_ST_STOP;                         // R3
            end else if (!coast_stop_input &&
                         (restart_delay == CST_DLY_ZERO ||
                          wait_q == CST_DLY_ZERO)) begin
               st_d = CST_ST_RUN;                          // R3 R5
            end
         end
         CST_ST_TRIP: begin
            if (clear_req) begin
               st_d = CST_ST_STOP;                         // R11 R9
            end
         end
      endcase
   end

   // state register; power-up guard check
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= CST_ST_STOP;
      end else if (first_q && powerup_autostart_guard && run_cmd) begin
         st_q <= CST_ST_TRIP;                              // R14
      end else begin
         st_q <= st_d;
      end
   end

   // autostart permission after a clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arm_q <= 1'b1;
      end else if (st_q == CST_ST_TRIP && clear_req) begin
         arm_q <= ~powerup_autostart_guard | reset_input_terminal; // R13
      end else if (run_rise || !run_cmd) begin
         arm_q <= 1'b1;                                    // R13
      end
   end

   // restart wait counter, loaded while coast input held
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_q <= CST_DLY_ZERO;
      end else if (st_q != CST_ST_COAST || coast_stop_input) begin
         wait_q <= restart_delay;                          // R5
      end else if (tick && wait_q != CST_DLY_ZERO) begin
         wait_q <= wait_q - 1'b1;                          // R5
      end
   end

   // power stage and restart mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         output_enable <= 1'b0;
         speed_match   <= 1'b0;
      end else begin
         output_enable <= (st_d == CST_ST_RUN) &&
                          !(first_q && powerup_autostart_guard); // R2 R8
         if (st_q == CST_ST_COAST && st_d == CST_ST_RUN)
            speed_match <= restart_speed_select
                           == CST_RESTART_MATCH;           // R4
         else if (st_d != CST_ST_RUN)
            speed_match <= 1'b0;
      end
   end

   // alarm and error display
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         alarm_out  <= 1'b0;
         error_code <= CST_ERR_NONE;
      end else if (first_q && powerup_autostart_guard && run_cmd) begin
         alarm_out  <= 1'b1;                               // R14
         error_code <= CST_ERR_GUARD;
      end else if (st_q != CST_ST_TRIP && st_d == CST_ST_TRIP) begin
         alarm_out  <= 1'b1;                               // R8
         error_code <= CST_ERR_EXTFLT;                     // R7
      end else if (st_d != CST_ST_TRIP) begin
         alarm_out  <= 1'b0;                               // R11
         error_code <= CST_ERR_NONE;
      end
   end

   // trip history, cleared only by reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trip_count <= 4'h0;
      end else if (st_q != CST_ST_TRIP && st_d == CST_ST_TRIP &&
                   trip_count != 4'hF) begin
         trip_count <= trip_count + 4'h1;                  // R10
      end
   end

   // checks on trip, coast, restart and guard behaviour
   a_trip_alarm: assert property ( // R8
      @(posedge clk_sys) disable iff (rst)
      (st_q != CST_ST_TRIP && st_d == CST_ST_TRIP) |=> alarm_out)
      else $error("alarm not raised on trip");
   a_trip_stays: assert property ( // R9
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_TRIP && !clear_req) |=> st_q == CST_ST_TRIP)
      else $error("trip left without clear");
   a_coast_off: assert property ( // R2
      @(posedge clk_sys) disable iff (rst)
      coast_stop_input |=> !output_enable)
      else $error("output on while coasting");
   a_run_needed: assert property ( // R3
      @(posedge clk_sys) disable iff (rst)
      !run_cmd |=> !output_enable)
      else $error("output on without run");
   a_trip_off: assert property ( // R8
      @(posedge clk_sys) disable iff (rst)
      st_q == CST_ST_TRIP |-> !output_enable)
      else $error("output on in trip");
   a_fault_code: assert property ( // R7
      @(posedge clk_sys) disable iff (rst)
      (external_fault_input && st_q != CST_ST_TRIP && !first_q)
      |=> error_code == CST_ERR_EXTFLT)
      else $error("fault code not shown");
   a_clear_alarm: assert property ( // R11
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_TRIP && clear_req) |=> !alarm_out)
      else $error("alarm kept after clear");
   a_zero_delay: assert property ( // R5
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_COAST && !coast_stop_input && run_cmd &&
       !external_fault_input && restart_delay == CST_DLY_ZERO)
      |=> output_enable)
      else $error("zero delay still waited");
   a_guard_trip: assert property ( // R14
      @(posedge clk_sys) disable iff (rst)
      (first_q && powerup_autostart_guard && run_cmd)
      |=> (error_code == CST_ERR_GUARD && !output_enable))
      else $error("guard trip missing");
   a_count_step: assert property ( // R10
      @(posedge clk_sys) disable iff (rst)
      $changed(trip_count) |-> trip_count == $past(trip_count) + 4'h1)
      else $error("trip history not monotonic");
   a_fall_no_trip: assert property ( // R10
      @(posedge clk_sys) disable iff (rst)
      (st_q != CST_ST_TRIP && !external_fault_input && !first_q)
      |=> st_q != CST_ST_TRIP)
      else $error("trip without fault edge");
   a_clear_stop: assert property ( // R11
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_TRIP && clear_req) |=> st_q == CST_ST_STOP)
      else $error("clear did not return to stop");
   a_guard_rearm: assert property ( // R13
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_TRIP && clear_req && !reset_input_terminal &&
       powerup_autostart_guard) |=> (!output_enable) [*2])
      else $error("guarded clear restarted at once");
   a_restart_run: assert property ( // R12
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_TRIP && clear_req && !powerup_autostart_guard)
      ##1 (run_cmd && !coast_stop_input && !external_fault_input)
      |=> output_enable)
      else $error("no restart with run held");
   a_speed_match: assert property ( // R4
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_COAST && st_d == CST_ST_RUN &&
       restart_speed_select == CST_RESTART_MATCH) |=> speed_match)
      else $error("restart did not match speed");
   a_speed_zero: assert property ( // R4
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_COAST && st_d == CST_ST_RUN &&
       restart_speed_select == CST_RESTART_ZERO) |=> !speed_match)
      else $error("restart from zero flagged match");
   a_coast_enter: assert property ( // R1
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_RUN && coast_stop_input && !external_fault_input)
      |=> st_q == CST_ST_COAST)
      else $error("coast input did not coast");
   a_wait_hold: assert property ( // R5
      @(posedge clk_sys) disable iff (rst)
      (st_q == CST_ST_COAST && wait_q != CST_DLY_ZERO &&
       restart_delay != CST_DLY_ZERO) |=> !output_enable)
      else $error("restart before delay ran out");
endmodule // cst_ctrl

// >>> verilog/cst_pkg.sv
// constants for the coast stop and external trip control block
package cst_pkg;
   localparam int          CST_NUM_TERM       = 5;        // input terminals
   localparam logic [7:0]  CST_FN_COAST       = 8'h0B;    // function code 11
   localparam logic [7:0]  CST_FN_EXTFLT      = 8'h0C;    // function code 12
   localparam logic [7:0]  CST_FN_GUARD       = 8'h0D;    // function code 13
   localparam logic [7:0]  CST_FN_RESET       = 8'h12;    // function code 18
   localparam logic [7:0]  CST_ERR_NONE       = 8'h00;    // no error shown
   localparam logic [7:0]  CST_ERR_EXTFLT     = 8'h0C;    // external fault
   localparam logic [7:0]  CST_ERR_GUARD      = 8'h0D;    // power-up guard
   localparam int          CST_CLK_HZ         = 40000000; // system clock
   localparam int          CST_TICK_US        = 100;      // delay unit in us
   localparam int          CST_TICK_CYC       =
      (CST_CLK_HZ / 1000000) * CST_TICK_US;               // cycles per unit
   localparam int          CST_DIV_W          = 13;       // divider width
   localparam logic [CST_DIV_W-1:0] CST_DIV_LAST =
      CST_DIV_W'(CST_TICK_CYC - 1);                       // divider top
   localparam int          CST_DLY_W          = 16;       // delay width
   localparam logic [15:0] CST_DLY_ZERO       = 16'h0000; // no wait
   localparam logic        CST_RESTART_ZERO   = 1'b0;     // restart at 0 Hz
   localparam logic        CST_RESTART_MATCH  = 1'b1;     // match rotation
   typedef enum logic [1:0] {
      CST_ST_STOP  = 2'b00,   // output off, idle
      CST_ST_RUN   = 2'b01,   // driving motor
      CST_ST_COAST = 2'b11,   // coasting, coast input or restart wait
      CST_ST_TRIP  = 2'b10    // latched trip
   } cst_state_t;
endpackage : cst_pkg

// >>> verilog/cst_term_in.sv
// one input terminal: polarity, double flop, edge detect
`timescale 1ns/10ps
module cst_term_in (
   input  wire logic clk_sys,     // system clock
   input  wire logic rst,         // sync reset, active high
   input  wire logic pin,         // raw terminal level
   input  wire logic invert,      // polarity: 1 = active low
   output logic      level,       // clean active level
   output logic      rise,        // off-to-on pulse
   output logic      fall         // on-to-off pulse
);
   logic meta_q;                  // first sync stage
   logic sync_q;                  // second sync stage
   logic last_q;                  // previous clean level

   // polarity then two flops; free running so levels are settled
   // by the time reset ends, which the power-up guard check needs
   always_ff @(posedge clk_sys) begin
      meta_q <= pin ^ invert;  // R15
      sync_q <= meta_q;
   end

   // history for edge detect; tracks through reset, no false edge
   always_ff @(posedge clk_sys) begin
      last_q <= sync_q;
   end

   assign level = sync_q;
   assign rise  = sync_q & ~last_q & ~rst;  // R15
   assign fall  = ~sync_q & last_q & ~rst;
endmodule // cst_term_in
